// file: mls_modem_loop_select.sv
// Operation
// R1: Send permit needs modem ready and clear-to-send
// R2: Ready, clear-to-send, ring readable as status
// R3: Option forces modem ready status always on
// R4: Interface select picks differential or inverted single-ended
// R5: Option forces request-to-send always asserted; the code forces it in user mode only, maintenance holds it off
// R6: Oscillator divided by two gives maintenance clock
// R7: External clock out only when switch enables
// R8: Loop select is loop request OR bit5
// R9: User mode: transmitter enable follows send permit
// R10: User mode: request-to-send follows its flop
// R11: User mode: receive data comes from modem
// R12: User mode: terminal ready follows its flop
// R13: Maintenance: transmitter enable follows request flop
// R14: Maintenance: request-to-send held off
// R15: Maintenance: transmit data looped to receiver
// R16: Maintenance: terminal ready held off
// R17: Integral variant: enable from inverted clear-to-send
// R18: Processor supplies single-step clock in internal maintenance
// R19: System test clocks from maintenance oscillator
// R20: External maintenance uses returned maintenance clock
// R21: Run and loop select pick clock source
// R22: Receive clock blocked in half duplex sending
// R23: Reset clears loop, terminal and request flops
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "mls_defs.svh"
module mls_modem_loop_select
	import mls_pkg::*;
#(
	parameter bit DSR_FORCE       = 1'b0,
	parameter bit RTS_FORCE       = 1'b0,
	parameter bit INTEGRAL_MODEM  = 1'b0,
	parameter int OSC_TICK_CYCLES = `MLS_OSC_TICK_CYCLES
)(
	input  wire logic                   SYS_CLK,
	input  wire logic                   RST,
	input  wire logic                   PSEL,
	input  wire logic                   PENABLE,
	input  wire logic                   PWRITE,
	input  wire logic [`MLS_ADDR_W-1:0] PADDR,
	input  wire logic [31:0]            PWDATA,
	output logic      [31:0]            PRDATA,
	output logic                        PREADY,
	output logic                        PSLVERR,
	input  wire logic                   MODEM_READY_IN,
	input  wire logic                   CLEAR_TO_SEND_IN,
	input  wire logic                   RING_IN,
	input  wire logic                   INTEGRAL_MODEM_CTS_N,
	input  wire logic                   SE_XMIT_CLOCK,
	input  wire logic                   SE_RECEIVE_DATA,
	input  wire logic                   SE_RECEIVE_CLOCK,
	input  wire logic                   DF_XMIT_CLOCK,
	input  wire logic                   DF_RECEIVE_DATA,
	input  wire logic                   DF_RECEIVE_CLOCK,
	input  wire logic                   TRANSMIT_LINE_DATA,
	input  wire logic                   RTS_SET,
	input  wire logic                   RTS_CLEAR,
	output logic                        TRANSMITTER_ENABLE,
	output logic                        REQUEST_SEND_OUT,
	output logic                        TERMINAL_READY_OUT,
	output logic                        SELECTED_RECEIVE_DATA,
	output logic                        TX_CLOCK,
	output logic                        RX_CLOCK,
	output logic                        EXTERNAL_CLOCK_OUT
);
	// ==========================================================
	// Pin synchronisers
	localparam int NSYNC = 10;
	localparam int S_RDY = 0;
	localparam int S_CTS = 1;
	localparam int S_RING = 2;
	localparam int S_CSN = 3;
	localparam int S_SE = 4;
	localparam int S_DF = 7;

	logic [NSYNC-1:0] pin_vec;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;

	assign pin_vec = {DF_RECEIVE_CLOCK, DF_RECEIVE_DATA, DF_XMIT_CLOCK,
		SE_RECEIVE_CLOCK, SE_RECEIVE_DATA, SE_XMIT_CLOCK,
		INTEGRAL_MODEM_CTS_N, RING_IN, CLEAR_TO_SEND_IN, MODEM_READY_IN};

	// Two stages; only the second stage feeds any logic
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pin_vec;
			sync2_reg <= sync1_reg;
		end
	end

	// ==========================================================
	// Interface select: index 0 transmit clock, 1 data, 2 receive clock
	logic [`MLS_CFG_W-1:0] cfg_reg;
	logic [`MLS_CFG_W-1:0] cfg_next;
	logic [2:0]            modem_sel;

	// Single-ended receivers invert, so that path is complemented
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_iface
			assign modem_sel[gi] = cfg_reg[`MLS_CFG_SE] ? ~sync2_reg[S_SE + gi]
				: sync2_reg[S_DF + gi]; // R4
		end
	endgenerate

	logic modem_xmit_clock;
	logic modem_receive_data;
	logic modem_recv_clock;
	assign modem_xmit_clock   = modem_sel[0];
	assign modem_receive_data = modem_sel[1];
	assign modem_recv_clock   = modem_sel[2];

	// ==========================================================
	// Modem status and mode select
	logic [`MLS_CTRL_W-1:0] ctrl_reg;
	logic [`MLS_CTRL_W-1:0] ctrl_next;
	logic                   request_send_flop_reg;
	logic                   request_send_flop_next;
	logic                   modem_ready_status;
	logic                   clear_to_send_status;
	logic                   ring_indicate_status;
	logic                   modem_send_permit;
	logic                   user_enable;
	logic                   loop_sel;
	logic                   cpu_loop_request;
	logic                   loopback_control_bit;
	logic                   run_flag;
	logic                   single_step_clock;
	logic                   half_duplex_select;
	logic                   terminal_ready_flop;
	logic                   maintenance_clock;

	assign cpu_loop_request     = ctrl_reg[`MLS_CTRL_LOOPREQ];
	assign loopback_control_bit = ctrl_reg[`MLS_CTRL_LOOPBACK];
	assign run_flag             = ctrl_reg[`MLS_CTRL_RUN];
	assign single_step_clock    = ctrl_reg[`MLS_CTRL_STEP];
	assign half_duplex_select   = ctrl_reg[`MLS_CTRL_HDX];
	assign terminal_ready_flop  = ctrl_reg[`MLS_CTRL_DTR];

	// Status and send permit; the forced option also satisfies the ready half of the permit
	assign modem_ready_status   = DSR_FORCE ? 1'b1 : sync2_reg[S_RDY]; // R3
	assign clear_to_send_status = sync2_reg[S_CTS];
	assign ring_indicate_status = sync2_reg[S_RING];
	assign modem_send_permit    = modem_ready_status & clear_to_send_status; // R1
	assign user_enable = INTEGRAL_MODEM ? ~sync2_reg[S_CSN] : modem_send_permit; // R17
	assign loop_sel = cpu_loop_request | loopback_control_bit; // R8

	mls_osc_divider #(
		.TICK_CYCLES(OSC_TICK_CYCLES)
	) u_osc (
		.SYS_CLK  (SYS_CLK),
		.RST      (RST),
		.maint_clk(maintenance_clock)
	);

	// ==========================================================
	// APB slave, zero wait states
	logic        acc_wr;
	logic        setup_rd;
	logic        addr_hit;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [`MLS_STAT_W-1:0] stat_vec;

	assign acc_wr   = PSEL & PENABLE & PWRITE;
	assign setup_rd = PSEL & ~PENABLE & ~PWRITE;
	assign addr_hit = (PADDR == `MLS_ADDR_CTRL) | (PADDR == `MLS_ADDR_CFG)
		| (PADDR == `MLS_ADDR_STAT);
	assign PREADY   = 1'b1;
	assign PSLVERR  = PSEL & PENABLE & ~addr_hit;
	assign PRDATA   = prdata_reg;

	assign stat_vec = {maintenance_clock, request_send_flop_reg, loop_sel,
		modem_send_permit, ring_indicate_status, clear_to_send_status,
		modem_ready_status}; // R2

	// Register writes, read capture in setup, transmitter request flop
	always_comb begin
		ctrl_next   = ctrl_reg;
		cfg_next    = cfg_reg;
		prdata_next = prdata_reg;
		if (acc_wr && PADDR == `MLS_ADDR_CTRL) begin
			ctrl_next = PWDATA[`MLS_CTRL_W-1:0];
		end
		if (acc_wr && PADDR == `MLS_ADDR_CFG) begin
			cfg_next = PWDATA[`MLS_CFG_W-1:0];
		end
		if (setup_rd) begin
			case (PADDR)
				`MLS_ADDR_CTRL: prdata_next = {26'h0, ctrl_reg};
				`MLS_ADDR_CFG:  prdata_next = {30'h0, cfg_reg};
				`MLS_ADDR_STAT: prdata_next = {25'h0, stat_vec}; // R2
				default:        prdata_next = 32'h0;
			endcase
		end
		// Set beats clear so a start request is never lost
		request_send_flop_next = request_send_flop_reg;
		if (RTS_CLEAR) begin
			request_send_flop_next = 1'b0;
		end
		if (RTS_SET) begin
			request_send_flop_next = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ctrl_reg              <= `MLS_CTRL_RST; // R23
			cfg_reg               <= `MLS_CFG_RST;
			prdata_reg            <= 32'h0;
			request_send_flop_reg <= 1'b0; // R23
		end else begin
			ctrl_reg              <= ctrl_next;
			cfg_reg               <= cfg_next;
			prdata_reg            <= prdata_next;
			request_send_flop_reg <= request_send_flop_next;
		end
	end

	// ==========================================================
	// Loop select and clock source outputs
	mls_clock_source_mux_type clock_source_mux;
	logic tx_enable_next;
	logic rts_out_next;
	logic dtr_out_next;
	logic rxdata_next;
	logic tx_clk_next;
	logic rx_clock_source_mux;
	logic rx_clk_next;
	logic ext_clk_next;

	// Run flag is the high select, loop select the low
	always_comb begin
		case ({run_flag, loop_sel}) // R21
			2'b00:   clock_source_mux = MLS_SRC_MODEM;
			2'b01:   clock_source_mux = MLS_SRC_STEP;
			2'b10:   clock_source_mux = MLS_SRC_SIM;
			2'b11:   clock_source_mux = MLS_SRC_MAINT;
			default: clock_source_mux = MLS_SRC_MODEM;
		endcase
	end

	// Mode multiplexer; off states win over the forced options
	always_comb begin
		tx_enable_next = loop_sel ? request_send_flop_reg : user_enable; // R9 R13
		rts_out_next   = 1'b0; // R14
		dtr_out_next   = 1'b0; // R16
		rxdata_next    = loop_sel ? TRANSMIT_LINE_DATA : modem_receive_data; // R11 R15
		if (!loop_sel) begin
			rts_out_next = RTS_FORCE | request_send_flop_reg; // R5 R10
			dtr_out_next = terminal_ready_flop; // R12
		end
		case (clock_source_mux)
			MLS_SRC_MODEM: begin
				tx_clk_next = modem_xmit_clock;
				rx_clock_source_mux  = modem_recv_clock;
			end
			MLS_SRC_STEP: begin
				tx_clk_next = single_step_clock; // R18
				rx_clock_source_mux  = single_step_clock;
			end
			MLS_SRC_SIM: begin
				// Modem inputs carry the turned-around maintenance clock
				tx_clk_next = modem_xmit_clock; // R20
				rx_clock_source_mux  = modem_recv_clock;
			end
			MLS_SRC_MAINT: begin
				tx_clk_next = maintenance_clock; // R19
				rx_clock_source_mux  = maintenance_clock;
			end
			default: begin
				tx_clk_next = 1'b0;
				rx_clock_source_mux  = 1'b0;
			end
		endcase
		rx_clk_next  = rx_clock_source_mux & ~(half_duplex_select & request_send_flop_reg); // R22
		ext_clk_next = cfg_reg[`MLS_CFG_EXTCLK] & maintenance_clock; // R7
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			TRANSMITTER_ENABLE    <= 1'b0;
			REQUEST_SEND_OUT      <= 1'b0;
			TERMINAL_READY_OUT    <= 1'b0;
			SELECTED_RECEIVE_DATA <= 1'b0;
			TX_CLOCK              <= 1'b0;
			RX_CLOCK              <= 1'b0;
			EXTERNAL_CLOCK_OUT    <= 1'b0;
		end else begin
			TRANSMITTER_ENABLE    <= tx_enable_next;
			REQUEST_SEND_OUT      <= rts_out_next;
			TERMINAL_READY_OUT    <= dtr_out_next;
			SELECTED_RECEIVE_DATA <= rxdata_next;
			TX_CLOCK              <= tx_clk_next;
			RX_CLOCK              <= rx_clk_next;
			EXTERNAL_CLOCK_OUT    <= ext_clk_next;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	a_permit_needs_both: assert property (!INTEGRAL_MODEM && !loop_sel // R1
		&& !(modem_ready_status && sync2_reg[S_CTS]) |=> !TRANSMITTER_ENABLE)
		else $error("transmitter enabled without modem permit");
	a_status_read_back: assert property (setup_rd && PADDR == `MLS_ADDR_STAT // R2
		|=> PRDATA[2:0] == $past({ring_indicate_status, clear_to_send_status,
		modem_ready_status}))
		else $error("status read does not show modem lines");
	a_ready_forced: assert property (DSR_FORCE |-> modem_ready_status) // R3
		else $error("forced modem ready not asserted");
	a_iface_rx_data: assert property (cfg_reg[`MLS_CFG_SE] && !loop_sel // R4
		|-> ##1 SELECTED_RECEIVE_DATA == !$past(sync2_reg[S_SE + 1]))
		else $error("single-ended data not complemented");
	a_user_enable: assert property (!INTEGRAL_MODEM && !loop_sel // R9
		&& modem_send_permit |=> TRANSMITTER_ENABLE)
		else $error("user mode enable does not follow permit");
	a_user_rts_dtr: assert property (!loop_sel |=> REQUEST_SEND_OUT // R10 R12
		== (RTS_FORCE | $past(request_send_flop_reg))
		&& TERMINAL_READY_OUT == $past(terminal_ready_flop))
		else $error("user mode modem requests wrong");
	a_maint_outputs: assert property (loop_sel |=> !REQUEST_SEND_OUT // R14 R16
		&& !TERMINAL_READY_OUT
		&& TRANSMITTER_ENABLE == $past(request_send_flop_reg)) // R13
		else $error("maintenance mode outputs wrong");
	a_loop_data: assert property (loop_sel && TRANSMIT_LINE_DATA // R15
		|=> SELECTED_RECEIVE_DATA)
		else $error("transmit data not looped back");
	a_loop_set_by_bit5: assert property (acc_wr && PADDR == `MLS_ADDR_CTRL // R8
		&& PWDATA[`MLS_CTRL_LOOPBACK] |=> loop_sel)
		else $error("bit 5 did not select loopback");
	a_ext_clk_off: assert property (!cfg_reg[`MLS_CFG_EXTCLK] // R7
		|=> !EXTERNAL_CLOCK_OUT)
		else $error("external clock driven while switched off");
	a_sys_test_clk: assert property (run_flag && loop_sel // R19 R21
		|=> TX_CLOCK == $past(maintenance_clock))
		else $error("system test clock not maintenance clock");
	a_rx_clk_block: assert property (half_duplex_select // R22
		&& request_send_flop_reg |=> !RX_CLOCK)
		else $error("receive clock not blocked in half duplex");
	a_rts_set_wins: assert property (RTS_SET |=> request_send_flop_reg) // R10
		else $error("request flop set lost");
	a_reset_clear: assert property (@(posedge SYS_CLK) disable iff (1'b0) // R23
		RST |=> !loop_sel && !request_send_flop_reg && !terminal_ready_flop)
		else $error("reset left a mode flop set");
endmodule

// file: mls_defs.svh
`ifndef MLS_DEFS_SVH
`define MLS_DEFS_SVH

// ==========================================================
// Register map, byte addresses on the APB side
`define MLS_ADDR_W        8
`define MLS_ADDR_CTRL     8'h00
`define MLS_ADDR_CFG      8'h04
`define MLS_ADDR_STAT     8'h08

// ==========================================================
// Control register fields
`define MLS_CTRL_W        6
`define MLS_CTRL_RST      6'h00
`define MLS_CTRL_DTR      0
`define MLS_CTRL_LOOPREQ  1
`define MLS_CTRL_RUN      2
`define MLS_CTRL_STEP     3
`define MLS_CTRL_HDX      4
`define MLS_CTRL_LOOPBACK 5

// ==========================================================
// Configuration register fields
`define MLS_CFG_W         2
`define MLS_CFG_RST       2'h0
`define MLS_CFG_SE        0
`define MLS_CFG_EXTCLK    1

// ==========================================================
// Status register fields
`define MLS_STAT_W        7
`define MLS_STAT_READY    0
`define MLS_STAT_CTS      1
`define MLS_STAT_RING     2
`define MLS_STAT_PERMIT   3
`define MLS_STAT_LOOP     4
`define MLS_STAT_RTSFLOP  5
`define MLS_STAT_MCLK     6

// ==========================================================
// Timing: 20 kHz oscillator period against the 40 ns system clock
`define MLS_CLK_PERIOD_NS 40
`define MLS_OSC_PERIOD_NS 50000
`define MLS_OSC_TICK_CYCLES (`MLS_OSC_PERIOD_NS / `MLS_CLK_PERIOD_NS)

`endif

// file: mls_pkg.sv
// ==========================================================
// Shared types
package mls_pkg;
	// Clock source selection, index is {run, loop}
	typedef enum logic [3:0] {
		MLS_SRC_MODEM = 4'b0001,
		MLS_SRC_STEP  = 4'b0010,
		MLS_SRC_SIM   = 4'b0100,
		MLS_SRC_MAINT = 4'b1000
	} mls_clock_source_mux_type;
endpackage

// file: mls_osc_divider.sv
`timescale 1ns/1ns
`include "mls_defs.svh"
// ==========================================================
// Maintenance oscillator and divide-by-two shaper
module mls_osc_divider #(
	parameter int TICK_CYCLES = `MLS_OSC_TICK_CYCLES
)(
	input  wire logic SYS_CLK,
	input  wire logic RST,
	output logic      maint_clk
);
	localparam int CW = $clog2(TICK_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

	generate
		if (TICK_CYCLES < 2) begin : g_chk
			$error("mls_osc_divider: TICK_CYCLES must be at least 2");
		end
	endgenerate

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic          clk_reg;
	logic          clk_next;
	logic          osc_tick;

	// Oscillator edge every period, the flop toggles on it
	always_comb begin
		osc_tick = (cnt_reg == LAST);
		cnt_next = osc_tick ? '0 : cnt_reg + 1'b1;
		clk_next = osc_tick ? ~clk_reg : clk_reg; // R6
	end

	// Free running: only reset stops it, as power-off would
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cnt_reg <= '0;
			clk_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			clk_reg <= clk_next;
		end
	end

	assign maint_clk = clk_reg;

	a_div_toggle_only_tick: assert property (@(posedge SYS_CLK) disable iff (RST) // R6
		(clk_reg != $past(clk_reg)) |-> ($past(cnt_reg) == LAST))
		else $error("maintenance clock toggled off its oscillator edge");
	a_div_tick_toggles: assert property (@(posedge SYS_CLK) disable iff (RST) // R6
		(osc_tick && !RST) |=> (clk_reg != $past(clk_reg)))
		else $error("maintenance clock missed its toggle");
endmodule

// file: mls_modem_model.sv
`timescale 1ns/1ns
// ==========================================================
// Far-side modem: status lines, clocks and data on one interface
module mls_modem_model (
	input  wire logic sys_clk,
	input  wire logic dsr_on,
	input  wire logic cts_req,
	input  wire logic ring_on,
	input  wire logic slow,
	input  wire logic iface_se,
	input  wire logic clk_lvl,
	input  wire logic data_bit,
	output logic      modem_ready_in,
	output logic      clear_to_send_in,
	output logic      ring_in,
	output logic      se_xmit_clock,
	output logic      se_receive_data,
	output logic      se_receive_clock,
	output logic      df_xmit_clock,
	output logic      df_receive_data,
	output logic      df_receive_clock
);
	logic [5:0] cts_lag = 6'h00;
	logic       junk    = 1'b0;

	// Slow answer lags six cycles; the unused interface toggles every cycle
	always @(posedge sys_clk) begin
		cts_lag <= {cts_lag[4:0], cts_req};
		junk    <= ~junk;
	end

	// Status lines, high means ON
	assign modem_ready_in   = dsr_on;
	assign clear_to_send_in = slow ? cts_lag[5] : cts_req;
	assign ring_in          = ring_on;

	// Single-ended receivers invert, differential ones do not
	assign se_xmit_clock    = iface_se ? ~clk_lvl : junk;
	assign se_receive_clock = iface_se ? ~clk_lvl : junk;
	assign se_receive_data  = iface_se ? ~data_bit : junk;
	assign df_xmit_clock    = iface_se ? junk : clk_lvl;
	assign df_receive_clock = iface_se ? junk : clk_lvl;
	assign df_receive_data  = iface_se ? junk : data_bit;
endmodule

// file: mls_modem_loop_select_bench.sv
`timescale 1ns/1ns
`include "mls_defs.svh"
module mls_modem_loop_select_bench;
	typedef struct {string name; logic [32:0] mask; logic [32:0] val;} mls_note_type;
	localparam int TICK = 4;
	logic         sys_clk = 1'b0;
	logic         rst, psel, penable, pwrite, pready, pslverr, flop, lp, ck, v;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, seed, r;
	logic         dsr, cts_req, ring, slow, iface_se, clk_lvl, dbit, txd, rts_set, rts_clear;
	logic         m_rdy, m_cts, m_ring, se_xc, se_rd, se_rc, df_xc, df_rd, df_rc;
	logic         te, rso, tro, srd, txc, rxc, ext;
	logic [5:0]   ctrl;
	logic [1:0]   cfg, src;
	logic [32:0]  m, e;
	int           err_count, checks;
	mls_note_type pin_q[$], rd_q[$], n;

	// ==========================================================
	// Clock, design and modem
	always #20 sys_clk = ~sys_clk;

	mls_modem_loop_select #(.OSC_TICK_CYCLES(TICK)) i_dut (
		.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.MODEM_READY_IN(m_rdy), .CLEAR_TO_SEND_IN(m_cts), .RING_IN(m_ring),
		.INTEGRAL_MODEM_CTS_N(1'b1), .SE_XMIT_CLOCK(se_xc), .SE_RECEIVE_DATA(se_rd),
		.SE_RECEIVE_CLOCK(se_rc), .DF_XMIT_CLOCK(df_xc), .DF_RECEIVE_DATA(df_rd),
		.DF_RECEIVE_CLOCK(df_rc), .TRANSMIT_LINE_DATA(txd), .RTS_SET(rts_set),
		.RTS_CLEAR(rts_clear), .TRANSMITTER_ENABLE(te), .REQUEST_SEND_OUT(rso),
		.TERMINAL_READY_OUT(tro), .SELECTED_RECEIVE_DATA(srd), .TX_CLOCK(txc),
		.RX_CLOCK(rxc), .EXTERNAL_CLOCK_OUT(ext));

	mls_modem_model i_modem (
		.sys_clk(sys_clk), .dsr_on(dsr), .cts_req(cts_req), .ring_on(ring), .slow(slow),
		.iface_se(iface_se), .clk_lvl(clk_lvl), .data_bit(dbit), .modem_ready_in(m_rdy),
		.clear_to_send_in(m_cts), .ring_in(m_ring), .se_xmit_clock(se_xc),
		.se_receive_data(se_rd), .se_receive_clock(se_rc), .df_xmit_clock(df_xc),
		.df_receive_data(df_rd), .df_receive_clock(df_rc));

	// ==========================================================
	// Helpers
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic compare_pin(input string nm, input logic [32:0] mk, ev, sv);
		checks++;
		if ((sv & mk) !== (ev & mk)) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ev & mk, sv & mk);
		end
	endtask

	task automatic compare_reg(input string nm, input logic [32:0] mk, ev, sv);
		checks++;
		if ((sv & mk) !== (ev & mk)) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ev & mk, sv & mk);
		end
	endtask

	// Pushed on a falling edge, judged at the next rising edge
	task automatic expect_pins(input string nm, input logic [32:0] mk, ev);
		pin_q.push_back('{nm, mk, ev});
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input string nm, input logic [32:0] mk, ev);
		rd_q.push_back('{nm, mk, ev});
		apb(a, 1'b0, 32'h0);
	endtask

	task automatic do_reset(input int cycles);
		rst <= 1'b1;
		repeat (cycles) @(posedge sys_clk);
		rst  <= 1'b0;
		flop = 1'b0;
		@(negedge sys_clk);
		expect_pins("reset pins", 33'h7f, 33'h0);
		rd(`MLS_ADDR_CTRL, "ctrl reset", 33'h1ffffffff, 33'h0);
		rd(`MLS_ADDR_CFG, "cfg reset", 33'h1ffffffff, 33'h0);
		rd(`MLS_ADDR_STAT, "stat reset", 33'h1ffffffbf, 33'h0);
	endtask

	task automatic final_report();
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================
	// Result watcher: oldest note against what the design shows
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
			n = rd_q.pop_front();
			compare_reg(n.name, n.mask, n.val, {pslverr, prdata});
		end
		if (pin_q.size() > 0) begin
			n = pin_q.pop_front();
			compare_pin(n.name, n.mask, n.val, {26'h0, ext, rxc, txc, srd, tro, rso, te});
		end
	end

	// Hang guard, far beyond the roughly 1300 cycles the run needs
	initial begin
		#(40 * 40000);
		err_count++;
		final_report();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{dsr, cts_req, ring, slow, iface_se, clk_lvl, dbit, txd, rts_set, rts_clear} = 10'h0;
		{err_count, checks, seed} = {32'h0, 32'h0, 32'h41};
		do_reset(8);
		// Status is read-only; unmapped place errors and keeps control intact
		apb(`MLS_ADDR_STAT, 1'b1, 32'hffffffff);
		rd(`MLS_ADDR_STAT, "stat ro", 33'h1ffffffbf, 33'h0);
		apb(8'h0c, 1'b1, 32'hffffffff);
		rd(8'h0c, "unmapped", 33'h1ffffffff, 33'h100000000);
		rd(`MLS_ADDR_CTRL, "ctrl kept", 33'h1ffffffff, 33'h0);
		// Random modem state, modes, clock sources and request flop
		for (int i = 0; i < 40; i++) begin
			r = xs();
			{slow, txd, dbit, clk_lvl, ring, cts_req, dsr} <= r[6:0];
			iface_se <= r[14];
			ctrl = r[13:8];
			cfg  = r[15:14];
			apb(`MLS_ADDR_CTRL, 1'b1, {r[31:6], ctrl});
			apb(`MLS_ADDR_CFG, 1'b1, {r[31:2], cfg});
			@(posedge sys_clk);
			rts_set   <= (r[17:16] != 2'd1);
			rts_clear <= r[16];
			flop = (r[17:16] != 2'd1);
			@(posedge sys_clk);
			rts_set   <= 1'b0;
			rts_clear <= 1'b0;
			repeat (14) @(posedge sys_clk);
			@(negedge sys_clk);
			lp  = ctrl[1] | ctrl[5];
			src = {ctrl[2], lp};
			ck  = (src == 2'b01) ? ctrl[3] : clk_lvl;
			m = {26'h0, ~cfg[1], src != 2'b11, src != 2'b11, 4'hf};
			e = {26'h0, 1'b0, ck & ~(ctrl[4] & flop), ck, lp ? txd : dbit,
				~lp & ctrl[0], ~lp & flop, lp ? flop : dsr & cts_req};
			expect_pins("mode pins", m, e);
			rd(`MLS_ADDR_CTRL, "ctrl", 33'h1ffffffff, {27'h0, ctrl});
			rd(`MLS_ADDR_CFG, "cfg", 33'h1ffffffff, {31'h0, cfg});
			rd(`MLS_ADDR_STAT, "stat", 33'h1ffffffbf,
				{26'h0, 1'b0, flop, lp, dsr & cts_req, ring, cts_req, dsr});
		end
		// Maintenance clock forwarded, half period of one oscillator tick
		apb(`MLS_ADDR_CFG, 1'b1, 32'h2);
		// One extra cycle, else a switch-on edge passes for a clock toggle
		repeat (2) @(negedge sys_clk);
		v = ext;
		for (int k = 0; k < 4 * TICK && ext === v; k++) @(negedge sys_clk);
		v = ext;
		repeat (TICK) begin
			expect_pins("mclk hold", 33'h40, {26'h0, v, 6'h0});
			@(negedge sys_clk);
		end
		expect_pins("mclk toggle", 33'h40, {26'h0, ~v, 6'h0});
		// Second reset in mid-run with the modem quiet
		@(posedge sys_clk);
		{dsr, cts_req, ring} <= 3'h0;
		repeat (4) @(posedge sys_clk);
		do_reset(2);
		repeat (2) @(posedge sys_clk);
		final_report();
	end
endmodule
